//--- rtl/gcp_bank.sv
// Purpose: Pin multiplexer for one bank of eight pins
// Assumes: Pin inputs synchronous to the system clock
// Notes: Mode set selects the pin's special function; unknown selections leave it undriven
`timescale 1ns/1ns
`default_nettype none
module gcp_bank
   import gcp_pkg::*;
#(
   parameter logic [7:0] SF_MASK = 8'h00,
   parameter logic [7:0] SPEC_OUT_MASK = 8'h00
)
(
   // Configuration
   gcp_bank_if.bank cfg,
   // Pads
   input wire logic [7:0] pin_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_o,
   // Special function side
   input wire logic [7:0] spec_drive_i
);
   logic [7:0] sf_eff;
   logic [7:0] gout;
   logic [7:0] spec_out;

   // Pins without a special-function bit behave as if it were zero
   assign sf_eff = cfg.sf & SF_MASK;
   assign gout = gcp_gpio_out(cfg.mode, cfg.dir, sf_eff);
   // Special function owns only the pins whose peripheral drives them
   assign spec_out = cfg.mode & ~sf_eff & SPEC_OUT_MASK;

   // Drive data or peripheral value; plain inputs stay released
   always_comb
   begin
      pin_oe_o = gout | spec_out;
      pin_o = (gout & cfg.data) | (spec_out & spec_drive_i);
   end

   // Reads always see the pad level, whatever drives it
   assign cfg.pin_lvl = pin_i;
endmodule // gcp_bank
`default_nettype wire

//--- rtl/gcp_bank_if.sv
// Purpose: Carries one bank's configuration to its pin logic and pin levels back
// Assumes: Eight pins per bank
// Notes: Register side drives the fields, pin side returns the sampled levels
`timescale 1ns/1ns
`default_nettype none
interface gcp_bank_if;
   logic [7:0] mode;
   logic [7:0] dir;
   logic [7:0] sf;
   logic [7:0] data;
   logic [7:0] pin_lvl;
   modport ctrl (output mode, output dir, output sf, output data, input pin_lvl);
   modport bank (input mode, input dir, input sf, input data, output pin_lvl);
endinterface
`default_nettype wire

//--- rtl/gcp_events.sv
// Purpose: Activity blink timer for the green LED and soft reset line watcher
// Assumes: Activity is a one-cycle pulse per network event
// Notes: A new event restarts the blink window
`timescale 1ns/1ns
`default_nettype none
module gcp_events
   import gcp_pkg::*;
#(
   parameter int unsigned BLINK_CYC = LED_BLINK_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Activity LED
   input wire logic net_act_i,
   input wire logic led_auto_i,
   output logic blink_o,
   // Soft reset line
   input wire logic init_is_input_i,
   input wire logic init_lvl_i,
   input wire logic trig_lvl_i,
   output logic soft_rst_o
);
   localparam int CW = $clog2(BLINK_CYC + 1);
   localparam logic [CW-1:0] BLINK_LOAD = CW'(BLINK_CYC);

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_blink_o;
   gcp_sr_state_e sr_state;
   gcp_sr_state_e next_sr_state;
   logic next_soft_rst_o;
   logic hit;

   // Blink window: LED lit for a fixed time after each activity event
   always_comb
   begin
      next_cnt = cnt;
      if (led_auto_i && net_act_i)
         next_cnt = BLINK_LOAD;
      else if (cnt != '0)
         next_cnt = cnt - CW'(1);
      if (!led_auto_i)
         next_cnt = '0;
      next_blink_o = (next_cnt != '0);
   end

   // One request per arrival at the trigger level; the line must leave it to re-arm
   assign hit = init_is_input_i && (init_lvl_i == trig_lvl_i);
   always_comb
   begin
      next_sr_state = sr_state;
      next_soft_rst_o = 1'b0;
      unique case (sr_state)
         GCP_SR_ARMED:
         begin
            if (hit)
            begin
               next_soft_rst_o = 1'b1;
               next_sr_state = GCP_SR_HELD;
            end
         end
         GCP_SR_HELD:
         begin
            if (!hit)
               next_sr_state = GCP_SR_ARMED;
         end
      endcase
   end

   // Registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt <= '0;
         blink_o <= 1'b0;
         sr_state <= GCP_SR_HELD;
         soft_rst_o <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         blink_o <= next_blink_o;
         sr_state <= next_sr_state;
         soft_rst_o <= next_soft_rst_o;
      end
   end
endmodule // gcp_events
`default_nettype wire

//--- rtl/gcp_pkg.sv
// Purpose: Shared constants, types and helpers of the GPIO pin configuration port
// Assumes: 50 MHz clock, APB register access, eight pins per bank
// Notes: Each bank word holds four 8-bit fields: mode, direction, special function, data
package gcp_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned LED_BLINK_MS = 50;
   localparam int unsigned LED_BLINK_CYC = (CLK_HZ / 1000) * LED_BLINK_MS;

   // Register byte addresses
   localparam logic [7:0] ADDR_BANK_FIRST = 8'h00;
   localparam logic [7:0] ADDR_BANK_SECOND = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;

   // Field positions inside a bank word
   localparam int unsigned FLD_MODE_LSB = 24;
   localparam int unsigned FLD_DIR_LSB = 16;
   localparam int unsigned FLD_SF_LSB = 8;
   localparam int unsigned FLD_DATA_LSB = 0;

   // Bank reset values: first bank in serial use, second bank LED output dark
   localparam logic [7:0] RST_FIRST_MODE = 8'hef;
   localparam logic [7:0] RST_FIRST_DIR = 8'h00;
   localparam logic [7:0] RST_FIRST_DATA = 8'h00;
   localparam logic [7:0] RST_SECOND_MODE = 8'h00;
   localparam logic [7:0] RST_SECOND_DIR = 8'h40;
   localparam logic [7:0] RST_SECOND_SF = 8'h00;
   localparam logic [7:0] RST_SECOND_DATA = 8'h40;

   // Per-bank structure: which pins own a special-function bit, and serial outputs
   localparam logic [7:0] FIRST_SF_MASK = 8'h00;
   localparam logic [7:0] SECOND_SF_MASK = 8'hff;
   localparam logic [7:0] FIRST_SPEC_OUT_MASK = 8'he0;
   localparam logic [7:0] SECOND_SPEC_OUT_MASK = 8'h00;
   localparam int unsigned LED_BIT = 6;
   localparam int unsigned INIT_BIT = 5;

   // Control and status register bits
   localparam int unsigned CTRL_LED_AUTO_BIT = 0;
   localparam int unsigned CTRL_TRIG_LVL_BIT = 1;
   localparam int unsigned STAT_INIT_LVL_BIT = 8;
   localparam int unsigned STAT_BLINK_BIT = 9;
   localparam logic [1:0] RST_CTRL = 2'h1;

   // Soft reset watcher states
   typedef enum logic [0:0] {GCP_SR_ARMED = 1'b0, GCP_SR_HELD = 1'b1} gcp_sr_state_e;

   // Pins acting as plain general inputs
   function automatic logic [7:0] gcp_gpio_in(input logic [7:0] mode, input logic [7:0] dir,
                                              input logic [7:0] sf);
      return ~mode & ~dir & ~sf;
   endfunction

   // Pins acting as plain general outputs
   function automatic logic [7:0] gcp_gpio_out(input logic [7:0] mode, input logic [7:0] dir,
                                               input logic [7:0] sf);
      return ~mode & dir & ~sf;
   endfunction
endpackage

//--- rtl/gcp_port.sv
// Purpose: Top of the sixteen-pin GPIO configuration port with its APB register file
// Assumes: 50 MHz CLK_I, synchronous active-low RESETN_I, pads synchronous to CLK_I
// Notes: Two bank words of eight pins each plus one control and status word
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module gcp_port
   import gcp_pkg::*;
#(
   parameter int unsigned BLINK_CYC = LED_BLINK_CYC
)
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESETN_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // First bank pads
   input wire logic [7:0] BANK_FIRST_PIN_I,
   output logic [7:0] BANK_FIRST_PIN_O,
   output logic [7:0] BANK_FIRST_PIN_OE_O,
   // Second bank pads
   input wire logic [7:0] BANK_SECOND_PIN_I,
   output logic [7:0] BANK_SECOND_PIN_O,
   output logic [7:0] BANK_SECOND_PIN_OE_O,
   // Serial controller side
   input wire logic [7:0] SER_DRIVE_I,
   output logic [7:0] SER_SENSE_O,
   // Network activity and soft reset request
   input wire logic NET_ACT_I,
   output logic SOFT_RESET_REQ_O
);
   gcp_bank_if first_if ();
   gcp_bank_if second_if ();

   // Bank state
   logic [7:0] f_mode;
   logic [7:0] f_dir;
   logic [7:0] f_data;
   logic [7:0] s_mode;
   logic [7:0] s_dir;
   logic [7:0] s_sf;
   logic [7:0] s_data;
   logic [1:0] ctrl;
   logic [7:0] next_f_mode;
   logic [7:0] next_f_dir;
   logic [7:0] next_f_data;
   logic [7:0] next_s_mode;
   logic [7:0] next_s_dir;
   logic [7:0] next_s_sf;
   logic [7:0] next_s_data;
   logic [1:0] next_ctrl;
   // Bus state
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [31:0] prdata;
   logic pslverr;
   logic setup;
   logic wr_en;
   logic mapped;
   logic [31:0] wmask;
   // Event side
   logic blink;
   logic init_is_input;
   logic [7:0] s_data_eff;
   logic [7:0] s_plain_in;

   // Merge a write into an 8-bit field honouring byte strobes
   function automatic logic [7:0] merge8(input logic [7:0] old, input int unsigned lsb,
                                         input logic [31:0] wd, input logic [31:0] m);
      logic [7:0] w;
      logic [7:0] k;
      w = wd[lsb +: 8];
      k = m[lsb +: 8];
      return (old & ~k) | (w & k);
   endfunction

   // Build one bank word from its fields
   function automatic logic [31:0] pack(input logic [7:0] mode, input logic [7:0] dir,
                                        input logic [7:0] sf, input logic [7:0] lvl);
      logic [31:0] w;
      w = '0;
      w[FLD_MODE_LSB +: 8] = mode;
      w[FLD_DIR_LSB +: 8] = dir;
      w[FLD_SF_LSB +: 8] = sf;
      w[FLD_DATA_LSB +: 8] = lvl;
      return w;
   endfunction

   // APB decode; zero wait states, the access phase always completes
   assign setup = PSEL_I && !PENABLE_I;
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
   assign mapped = (PADDR_I == ADDR_BANK_FIRST) || (PADDR_I == ADDR_BANK_SECOND) ||
                   (PADDR_I == ADDR_CTRL);
   assign wmask = {{8{PSTRB_I[3]}}, {8{PSTRB_I[2]}}, {8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
   assign PREADY_O = 1'b1;
   assign PRDATA_O = prdata;
   assign PSLVERR_O = pslverr && PSEL_I && PENABLE_I;

   // Register writes; only the addressed word changes, others keep their pins
   always_comb
   begin
      next_f_mode = f_mode;
      next_f_dir = f_dir;
      next_f_data = f_data;
      next_s_mode = s_mode;
      next_s_dir = s_dir;
      next_s_sf = s_sf;
      next_s_data = s_data;
      next_ctrl = ctrl;
      if (wr_en && PADDR_I == ADDR_BANK_FIRST)
      begin
         next_f_mode = merge8(f_mode, FLD_MODE_LSB, PWDATA_I, wmask);
         next_f_dir = merge8(f_dir, FLD_DIR_LSB, PWDATA_I, wmask);
         // Data kept regardless of direction, so it appears once output
         next_f_data = merge8(f_data, FLD_DATA_LSB, PWDATA_I, wmask);
      end
      if (wr_en && PADDR_I == ADDR_BANK_SECOND)
      begin
         next_s_mode = merge8(s_mode, FLD_MODE_LSB, PWDATA_I, wmask);
         next_s_dir = merge8(s_dir, FLD_DIR_LSB, PWDATA_I, wmask);
         next_s_sf = merge8(s_sf, FLD_SF_LSB, PWDATA_I, wmask);
         next_s_data = merge8(s_data, FLD_DATA_LSB, PWDATA_I, wmask);
      end
      if (wr_en && PADDR_I == ADDR_CTRL && PSTRB_I[0])
         next_ctrl = PWDATA_I[1:0];
   end

   // Read data captured in the setup phase so PRDATA comes from flip-flops
   always_comb
   begin
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (setup)
      begin
         next_pslverr = !mapped;
         next_prdata = '0;
         if (!PWRITE_I)
         begin
            unique case (PADDR_I)
               // Special-function field reads zero in the first bank
               ADDR_BANK_FIRST:
                  next_prdata = pack(f_mode, f_dir, FIRST_SF_MASK, first_if.pin_lvl);
               ADDR_BANK_SECOND:
                  next_prdata = pack(s_mode, s_dir, s_sf, second_if.pin_lvl);
               ADDR_CTRL:
               begin
                  next_prdata[CTRL_LED_AUTO_BIT] = ctrl[CTRL_LED_AUTO_BIT];
                  next_prdata[CTRL_TRIG_LVL_BIT] = ctrl[CTRL_TRIG_LVL_BIT];
                  next_prdata[STAT_INIT_LVL_BIT] = second_if.pin_lvl[INIT_BIT];
                  next_prdata[STAT_BLINK_BIT] = blink;
               end
               default:
                  next_prdata = '0;
            endcase
         end
      end
   end

   // State registers; synchronous reset holds everything while RESETN_I is low
   always_ff @(posedge CLK_I)
   begin
      if (!RESETN_I)
      begin
         f_mode <= RST_FIRST_MODE;
         f_dir <= RST_FIRST_DIR;
         f_data <= RST_FIRST_DATA;
         s_mode <= RST_SECOND_MODE;
         s_dir <= RST_SECOND_DIR;
         s_sf <= RST_SECOND_SF;
         s_data <= RST_SECOND_DATA;
         ctrl <= RST_CTRL;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         f_mode <= next_f_mode;
         f_dir <= next_f_dir;
         f_data <= next_f_data;
         s_mode <= next_s_mode;
         s_dir <= next_s_dir;
         s_sf <= next_s_sf;
         s_data <= next_s_data;
         ctrl <= next_ctrl;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // Activity blink pulls the LED pin low; the stored data bit is untouched
   always_comb
   begin
      s_data_eff = s_data;
      s_data_eff[LED_BIT] = s_data[LED_BIT] & ~blink;
   end

   // Line 5 is watched only while it is a plain input
   assign s_plain_in = gcp_gpio_in(s_mode, s_dir, s_sf);
   assign init_is_input = s_plain_in[INIT_BIT];

   // Bank configuration to the pin logic
   assign first_if.mode = f_mode;
   assign first_if.dir = f_dir;
   assign first_if.sf = FIRST_SF_MASK;
   assign first_if.data = f_data;
   assign second_if.mode = s_mode;
   assign second_if.dir = s_dir;
   assign second_if.sf = s_sf;
   assign second_if.data = s_data_eff;

   // Serial controller sees the first-bank pad levels
   assign SER_SENSE_O = first_if.pin_lvl;

   // First bank: serial lines or general pins
   gcp_bank #(
      .SF_MASK(FIRST_SF_MASK),
      .SPEC_OUT_MASK(FIRST_SPEC_OUT_MASK)
   ) u_first (
      .cfg(first_if.bank),
      .pin_i(BANK_FIRST_PIN_I),
      .pin_o(BANK_FIRST_PIN_O),
      .pin_oe_o(BANK_FIRST_PIN_OE_O),
      .spec_drive_i(SER_DRIVE_I)
   );

   // Second bank: LED, free line and reserved pins
   gcp_bank #(
      .SF_MASK(SECOND_SF_MASK),
      .SPEC_OUT_MASK(SECOND_SPEC_OUT_MASK)
   ) u_second (
      .cfg(second_if.bank),
      .pin_i(BANK_SECOND_PIN_I),
      .pin_o(BANK_SECOND_PIN_O),
      .pin_oe_o(BANK_SECOND_PIN_OE_O),
      .spec_drive_i(8'h00)
   );

   // LED blink timer and soft reset watcher
   gcp_events #(
      .BLINK_CYC(BLINK_CYC)
   ) u_events (
      .clk(CLK_I),
      .rst_n(RESETN_I),
      .net_act_i(NET_ACT_I),
      .led_auto_i(ctrl[CTRL_LED_AUTO_BIT]),
      .blink_o(blink),
      .init_is_input_i(init_is_input),
      .init_lvl_i(BANK_SECOND_PIN_I[INIT_BIT]),
      .trig_lvl_i(ctrl[CTRL_TRIG_LVL_BIT]),
      .soft_rst_o(SOFT_RESET_REQ_O)
   );
endmodule // gcp_port
`default_nettype wire

//--- tb/gcp_host_model.sv
// Purpose: Embedded host and board wiring at the sixteen pads
// Assumes: Host drives released pins at fixed levels
// Notes: Host never fights a pin the port drives
`timescale 1ns/1ns
`default_nettype none
module gcp_host_model
#(
   parameter logic [7:0] HOST_FIRST = 8'h5a,
   parameter logic [7:0] HOST_SECOND = 8'h00
)
(
   // Port drive
   input wire logic [7:0] first_o_i,
   input wire logic [7:0] first_oe_i,
   input wire logic [7:0] second_o_i,
   input wire logic [7:0] second_oe_i,
   // Soft reset button
   input wire logic pull_low_i,
   // Resolved pads
   output logic [7:0] first_pad_o,
   output logic [7:0] second_pad_o
);
   logic [7:0] ext_second;
   // Line 5 idles high through its pull-up; host pulls it low as a button
   always_comb
   begin
      ext_second = HOST_SECOND;
      ext_second[5] = !pull_low_i;
   end
   // Wire level: port where it drives, host elsewhere
   assign first_pad_o = (first_oe_i & first_o_i) | (~first_oe_i & HOST_FIRST);
   assign second_pad_o = (second_oe_i & second_o_i) | (~second_oe_i & ext_second);
endmodule // gcp_host_model
`default_nettype wire

//--- tb/gcp_port_asserts.sv
// Purpose: Port-level checks of the GPIO configuration port
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the top from tb_top; sees top ports only
`timescale 1ns/1ns
`default_nettype none
module gcp_port_asserts
   import gcp_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESETN_I,
   // APB
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // Pads and side lines
   input wire logic [7:0] BANK_FIRST_PIN_I,
   input wire logic [7:0] BANK_FIRST_PIN_OE_O,
   input wire logic [7:0] BANK_SECOND_PIN_O,
   input wire logic [7:0] BANK_SECOND_PIN_OE_O,
   input wire logic [7:0] SER_SENSE_O,
   input wire logic SOFT_RESET_REQ_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);

   // Access decode; only the two banks and the control word are mapped
   logic acc;
   logic wr_acc;
   logic mapped;
   assign acc = PSEL_I && PENABLE_I;
   assign wr_acc = acc && PWRITE_I;
   assign mapped = PADDR_I inside {ADDR_BANK_FIRST, ADDR_BANK_SECOND, ADDR_CTRL};

   a_ready_high: assert property (PSEL_I |-> PREADY_O)
      else $error("pready low in a transfer");
   a_err_unmapped: assert property (acc && !mapped |-> PSLVERR_O)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (acc && mapped |-> !PSLVERR_O)
      else $error("error on mapped access");
   a_err_access: assert property (PSLVERR_O |-> acc)
      else $error("error outside access phase");
   a_sense_follows: assert property (SER_SENSE_O == BANK_FIRST_PIN_I)
      else $error("serial sense differs from pads");
   a_soft_single: assert property (SOFT_RESET_REQ_O |=> !SOFT_RESET_REQ_O)
      else $error("soft reset request longer than one cycle");
   a_soft_input: assert property (SOFT_RESET_REQ_O |->
      $past(BANK_SECOND_PIN_OE_O[5]) == 1'b0)
      else $error("soft reset request while line driven");
   // Enables move only after a write edge; an early or unprompted update shows here
   a_oe_hold: assert property (!$past(wr_acc) |->
      $stable(BANK_FIRST_PIN_OE_O) && $stable(BANK_SECOND_PIN_OE_O))
      else $error("pin enable changed without a write");
   a_reset_pins: assert property (disable iff (1'b0) !RESETN_I |=>
      BANK_FIRST_PIN_OE_O == 8'he0 && BANK_SECOND_PIN_OE_O == 8'h40 &&
      BANK_SECOND_PIN_O == 8'h40)
      else $error("pins not at reset state");
endmodule // gcp_port_asserts
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the GPIO configuration port
// Assumes: Host levels 5a on first bank, pull-up only on line 5
// Notes: Short blink window so the activity test stays brief
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import gcp_pkg::*;
;
   localparam int unsigned BLINK = 8;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] f_in, f_o, f_oe, s_in, s_o, s_oe;
   logic net_act = 1'b0;
   logic pull_low = 1'b0;
   logic soft_req;
   int mismatches = 0;
   int checks = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   gcp_port #(.BLINK_CYC(BLINK)) dut_u (.CLK_I(clk), .RESETN_I(resetn), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .BANK_FIRST_PIN_I(f_in), .BANK_FIRST_PIN_O(f_o), .BANK_FIRST_PIN_OE_O(f_oe),
      .BANK_SECOND_PIN_I(s_in), .BANK_SECOND_PIN_O(s_o), .BANK_SECOND_PIN_OE_O(s_oe),
      .SER_DRIVE_I(8'ha0), .SER_SENSE_O(), .NET_ACT_I(net_act), .SOFT_RESET_REQ_O(soft_req));
   gcp_host_model host_u (.first_o_i(f_o), .first_oe_i(f_oe), .second_o_i(s_o),
      .second_oe_i(s_oe), .pull_low_i(pull_low), .first_pad_o(f_in), .second_pad_o(s_in));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; the idle edge first keeps back-to-back calls race-free
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Wait states end only when pready comes; a hang is left to the watchdog
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check(what, q, exp);
   endtask

   // Count request pulses over ten cycles
   task automatic count_soft(input int exp, input string what);
      int p;
      p = 0;
      repeat (10)
      begin
         @(posedge clk);
         #1;
         p += int'(soft_req === 1'b1);
      end
      check(what, 32'(p), 32'(exp));
   endtask

   task automatic t_reset_values();
      rd(ADDR_BANK_FIRST, 32'hef00_00ba, "first reset");
      rd(ADDR_BANK_SECOND, 32'h0040_0060, "second reset");
      rd(ADDR_CTRL, 32'h0000_0101, "ctrl reset");
      check("first oe", 32'(f_oe), 32'he0);
      check("serial out", 32'(f_o[7:5]), 32'h5);
      $display("reset values done");
   endtask

   // Bit 4 kept at its reset fields throughout
   task automatic t_first_gpio();
      wr(ADDR_BANK_FIRST, 32'h0000_ff2c);
      rd(ADDR_BANK_FIRST, 32'h0000_005a, "first inputs");
      check("first oe in", 32'(f_oe), 32'h0);
      wr(ADDR_BANK_FIRST, 32'h00ef_002c);
      rd(ADDR_BANK_FIRST, 32'h00ef_003c, "first outputs");
      check("first drive", 32'(f_o & f_oe), 32'h2c);
      wr(ADDR_BANK_FIRST, 32'hef00_0000);
      $display("first bank done");
   endtask

   task automatic t_second_rmw();
      logic [31:0] q;
      logic e;
      apb(1'b0, ADDR_BANK_SECOND, 32'h0, q, e);
      q[16 + INIT_BIT] = 1'b1;
      q[INIT_BIT] = 1'b0;
      wr(ADDR_BANK_SECOND, q);
      #1;
      check("line5 out oe", 32'(s_oe), 32'h60);
      check("line5 out", 32'(s_o & s_oe), 32'h40);
      wr(ADDR_BANK_SECOND, 32'h0060_2040);
      #1;
      check("sf release", 32'(s_oe), 32'h40);
      rd(ADDR_BANK_SECOND, 32'h0060_2060, "second sf");
      wr(ADDR_BANK_SECOND, 32'h0040_0040);
      $display("second bank done");
   endtask

   task automatic t_unmapped();
      logic [31:0] q;
      logic e;
      apb(1'b1, 8'h0c, 32'hffff_ffff, q, e);
      check("wr error", 32'(e), 32'h1);
      apb(1'b0, 8'h0c, 32'h0, q, e);
      check("rd error", 32'(e), 32'h1);
      check("rd zero", q, 32'h0);
      rd(ADDR_CTRL, 32'h0000_0101, "ctrl kept");
      $display("unmapped done");
   endtask

   task automatic t_blink();
      @(posedge clk);
      net_act <= 1'b1;
      @(posedge clk);
      net_act <= 1'b0;
      #1;
      check("led lit", 32'(s_o[LED_BIT]), 32'h0);
      // Status read takes three edges of the blink window
      rd(ADDR_CTRL, 32'h0000_0301, "blink status");
      repeat (BLINK - 4) @(posedge clk);
      #1;
      check("led still lit", 32'(s_o[LED_BIT]), 32'h0);
      @(posedge clk);
      #1;
      check("led dark", 32'(s_o[LED_BIT]), 32'h1);
      wr(ADDR_CTRL, 32'h0);
      net_act <= 1'b1;
      @(posedge clk);
      net_act <= 1'b0;
      repeat (2) @(posedge clk);
      check("no auto blink", 32'(s_o[LED_BIT]), 32'h1);
      wr(ADDR_BANK_SECOND, 32'h0040_0000);
      #1;
      check("led low", 32'(s_o[LED_BIT]), 32'h0);
      wr(ADDR_BANK_SECOND, 32'h0040_0040);
      wr(ADDR_CTRL, 32'h1);
      $display("blink done");
   endtask

   task automatic t_soft();
      @(posedge clk);
      pull_low <= 1'b1;
      count_soft(1, "low trigger");
      // Release first so the watcher re-arms before the trigger level flips
      @(posedge clk);
      pull_low <= 1'b0;
      wr(ADDR_CTRL, 32'h3);
      count_soft(1, "high trigger");
      // Driven low, then high: reaching the level while driven must not count
      wr(ADDR_BANK_SECOND, 32'h0060_0040);
      wr(ADDR_BANK_SECOND, 32'h0060_0060);
      count_soft(0, "driven line");
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_BANK_SECOND, 32'h0040_0040);
      $display("soft reset done");
   endtask

   task automatic t_hard_reset();
      wr(ADDR_BANK_FIRST, 32'h0000_0000);
      #1;
      check("oe cleared", 32'(f_oe), 32'h0);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      check("oe in reset", 32'(f_oe), 32'he0);
      resetn <= 1'b1;
      rd(ADDR_BANK_FIRST, 32'hef00_00ba, "after reset");
      $display("hard reset done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_reset_values();
      t_first_gpio();
      t_second_rmw();
      t_unmapped();
      t_blink();
      t_soft();
      t_hard_reset();
      complete_run();
   end

   // Watchdog; the sequence needs well under a thousand cycles
   initial
   begin
      #40000;
      mismatches++;
      complete_run();
   end
endmodule // tb_top

bind gcp_port gcp_port_asserts chk_u (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .BANK_FIRST_PIN_I(BANK_FIRST_PIN_I),
   .BANK_FIRST_PIN_OE_O(BANK_FIRST_PIN_OE_O), .BANK_SECOND_PIN_O(BANK_SECOND_PIN_O),
   .BANK_SECOND_PIN_OE_O(BANK_SECOND_PIN_OE_O), .SER_SENSE_O(SER_SENSE_O),
   .SOFT_RESET_REQ_O(SOFT_RESET_REQ_O));
`default_nettype wire
